/* hdl/rps_device.sv */
`timescale 1ns/1ps
module rps_device import rps_pkg::*; #(
   parameter int unsigned RAMP = RAMP_CYCLES
) (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // control pins from the host
   rps_if.device     pins,
   // state of the chip sections
   output logic      regulator_enable_o,
   output logic      wlan_powered_o,
   output logic      wlan_bus_enable_o,
   output logic      bt_active_o,
   output logic      fm_active_o,
   output logic      bt_bus_enable_o
);
   logic [3:0]  pin_s;
   logic        next_reg_en;
   logic [31:0] ramp_cnt;
   logic        supply_good;

   // pins come from another domain
   rps_sync #(.WIDTH(4)) u_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   ({pins.bluetooth_core_reset_n, pins.wlan_core_reset_n,
               pins.bluetooth_power_request, pins.wlan_power_request}),
      .q_o   (pin_s)
   );

   assign next_reg_en = pin_s[0] | pin_s[1];

   // regulator enable and supply ramp model
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         regulator_enable_o <= 1'b0;
         ramp_cnt           <= 32'h0;
         supply_good        <= 1'b0;
      end else begin
         regulator_enable_o <= next_reg_en;
         if (!next_reg_en) begin
            ramp_cnt    <= 32'h0;
            supply_good <= 1'b0;
         end else if (ramp_cnt < RAMP - 1) begin
            ramp_cnt <= ramp_cnt + 32'h1;
         end else begin
            supply_good <= 1'b1;
         end
      end
   end

   assign pins.core_supply_rail = supply_good;

   // core power and reset state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wlan_powered_o    <= 1'b0;
         wlan_bus_enable_o <= 1'b0;
         bt_active_o       <= 1'b0;
         fm_active_o       <= 1'b0;
         bt_bus_enable_o   <= 1'b0;
      end else begin
         wlan_powered_o    <= supply_good & pin_s[2];
         wlan_bus_enable_o <= supply_good & pin_s[2];
         bt_active_o       <= supply_good & pin_s[3];
         fm_active_o       <= supply_good & pin_s[3];
         bt_bus_enable_o   <= supply_good & pin_s[3];
      end
   end
endmodule

/* hdl/rps_host.sv */
// Design decisions made here: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
// Functional notes
// - wait 150 ms after supply before access
// - regulators enabled by either request
// - wlan reset low keeps wlan off
// - wlan reset active low, always driven
// - bt reset active low, always driven
// - fm shares bt reset; fm needs bt
// - sequencing delays are minimums only
// - requests share one regulator; each reset gates its own sections
module rps_host import rps_pkg::*; #(
   parameter int unsigned HOLDOFF = HOLDOFF_CYCLES,
   parameter int unsigned SETTLE  = SETTLE_CYCLES,
   parameter int unsigned RHOLD   = RST_HOLD_CYCLES
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone classic slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [3:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // control pins to the chip
   rps_if.host              pins,
   // readiness
   output logic             bus_access_ok_o,
   output logic             wlan_ready_o,
   output logic             bt_ready_o
);
   logic [2:0]  ctrl;
   logic [1:0]  want;
   logic        supply_s;
   logic [31:0] hold_cnt;
   logic        access_ok;
   logic [1:0]  core_req;
   logic [1:0]  core_rst_n;
   logic [1:0]  core_on;
   logic [1:0]  core_busy;
   logic [31:0] status;
   logic        bus_req;
   logic        next_ack;
   logic        wr_ctrl;

   // supply level comes from the chip
   rps_sync #(.WIDTH(1)) u_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   (pins.core_supply_rail),
      .q_o   (supply_s)
   );

   // wishbone request and single-cycle acknowledge
   assign bus_req  = cyc_i & stb_i;
   assign next_ack = bus_req & ~ack_o;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= next_ack;
      end
   end

   // control register write, low byte lane only; it lands at the edge where
   // the master samples ack high, so the write and the handshake end together
   assign wr_ctrl = bus_req & ack_o & we_i & sel_i[0] & (adr_i == CTRL_ADDR);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl <= dat_i[2:0];
      end
   end

   assign want[CORE_WLAN] = ctrl[CTRL_WLAN_BIT];
   assign want[CORE_BT]   = ctrl[CTRL_BT_BIT] | ctrl[CTRL_FM_BIT];

   // status word
   always_comb begin
      status                  = 32'h0;
      status[ST_WLAN_ON_BIT]  = core_on[CORE_WLAN];
      status[ST_BT_ON_BIT]    = core_on[CORE_BT];
      status[ST_FM_OK_BIT]    = core_on[CORE_BT] & ctrl[CTRL_FM_BIT];
      status[ST_SUPPLY_BIT]   = supply_s;
      status[ST_ACCESS_BIT]   = access_ok;
      status[ST_WLAN_BSY_BIT] = core_busy[CORE_WLAN];
      status[ST_BT_BSY_BIT]   = core_busy[CORE_BT];
   end

   // read data, unmapped offsets read zero
   // latched with the ack flop, so it stands for the whole ack cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0;
      end else if (next_ack && !we_i) begin
         unique case (adr_i)
            CTRL_ADDR:   dat_o <= {29'h0, ctrl};
            STATUS_ADDR: dat_o <= status;
            default:     dat_o <= 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hold_cnt  <= 32'h0;
         access_ok <= 1'b0;
      end else if (!supply_s) begin
         hold_cnt  <= 32'h0;
         access_ok <= 1'b0;
      end else if (hold_cnt < HOLDOFF - 1) begin
         hold_cnt <= hold_cnt + 32'h1;
      end else begin
         access_ok <= 1'b1;
      end
   end

   // per-core power sequence
   for (genvar c = 0; c < 2; c++) begin : g_core
      rps_core_state_t state;
      logic [31:0]     cnt;

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            state <= CS_OFF;
            cnt   <= 32'h0;
         end else begin
            unique case (state)
               CS_OFF: begin
                  cnt <= 32'h0;
                  if (want[c]) begin
                     state <= CS_RAMP;
                  end
               end
               CS_RAMP: begin
                  if (!want[c]) begin
                     cnt   <= 32'h0;
                     state <= CS_DOWN;
                  end else if (!supply_s) begin
                     cnt <= 32'h0;
                  end else if (cnt < SETTLE - 1) begin
                     cnt <= cnt + 32'h1;
                  end else begin
                     cnt   <= 32'h0;
                     state <= CS_ON;
                  end
               end
               CS_ON: begin
                  cnt <= 32'h0;
                  if (!want[c] || !supply_s) begin
                     state <= CS_DOWN;
                  end
               end
               CS_DOWN: begin
                  if (cnt < RHOLD - 1) begin
                     cnt <= cnt + 32'h1;
                  end else begin
                     cnt   <= 32'h0;
                     state <= CS_OFF;
                  end
               end
            endcase
         end
      end

      assign core_req[c]   = ~state[0];
      assign core_rst_n[c] = state[2];
      assign core_on[c]    = state[2];
      assign core_busy[c]  = state[1] | state[3];
   end

   // pins always actively driven
   // each pin decodes one state bit, so it cannot glitch
   assign pins.wlan_power_request      = core_req[CORE_WLAN];
   assign pins.bluetooth_power_request = core_req[CORE_BT];
   assign pins.wlan_core_reset_n       = core_rst_n[CORE_WLAN];
   assign pins.bluetooth_core_reset_n  = core_rst_n[CORE_BT];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_access_ok_o <= 1'b0;
         wlan_ready_o    <= 1'b0;
         bt_ready_o      <= 1'b0;
      end else begin
         bus_access_ok_o <= access_ok;
         wlan_ready_o    <= access_ok & core_on[CORE_WLAN];
         bt_ready_o      <= access_ok & core_on[CORE_BT];
      end
   end
endmodule

/* hdl/rps_if.sv */
`timescale 1ns/1ps
interface rps_if;
   logic wlan_power_request;
   logic bluetooth_power_request;
   logic wlan_core_reset_n;
   logic bluetooth_core_reset_n;
   logic core_supply_rail;

   modport host (
      output wlan_power_request,
      output bluetooth_power_request,
      output wlan_core_reset_n,
      output bluetooth_core_reset_n,
      input  core_supply_rail
   );

   modport device (
      input  wlan_power_request,
      input  bluetooth_power_request,
      input  wlan_core_reset_n,
      input  bluetooth_core_reset_n,
      output core_supply_rail
   );
endinterface

/* hdl/rps_pkg.sv */
package rps_pkg;
   // clock rate of clk_i
   localparam int unsigned CLK_HZ          = 40_000_000;
   localparam int unsigned CLK_PER_US      = CLK_HZ / 1_000_000;
   localparam int unsigned CLK_PER_MS      = CLK_HZ / 1_000;

   // least wait after the core supply settles before bus access
   localparam int unsigned HOLDOFF_MS      = 150;
   localparam int unsigned HOLDOFF_CYCLES  = HOLDOFF_MS * CLK_PER_MS;

   // least regulator settling time before a core reset is released
   localparam int unsigned SETTLE_US       = 10;
   localparam int unsigned SETTLE_CYCLES   = SETTLE_US * CLK_PER_US;

   // least reset time before a power request is dropped
   localparam int unsigned RST_HOLD_US     = 1;
   localparam int unsigned RST_HOLD_CYCLES = RST_HOLD_US * CLK_PER_US;

   // ramp time of the internal core supply
   localparam int unsigned RAMP_US         = 5;
   localparam int unsigned RAMP_CYCLES     = RAMP_US * CLK_PER_US;

   // register word offsets (byte addresses)
   localparam logic [3:0]  CTRL_ADDR       = 4'h0;
   localparam logic [3:0]  STATUS_ADDR     = 4'h4;

   // control field positions
   localparam int unsigned CTRL_WLAN_BIT   = 0;
   localparam int unsigned CTRL_BT_BIT     = 1;
   localparam int unsigned CTRL_FM_BIT     = 2;
   localparam logic [2:0]  CTRL_RESET      = 3'h0;

   // status field positions
   localparam int unsigned ST_WLAN_ON_BIT  = 0;
   localparam int unsigned ST_BT_ON_BIT    = 1;
   localparam int unsigned ST_FM_OK_BIT    = 2;
   localparam int unsigned ST_SUPPLY_BIT   = 3;
   localparam int unsigned ST_ACCESS_BIT   = 4;
   localparam int unsigned ST_WLAN_BSY_BIT = 5;
   localparam int unsigned ST_BT_BSY_BIT   = 6;

   // core index
   localparam int unsigned CORE_WLAN       = 0;
   localparam int unsigned CORE_BT         = 1;

   // per-core power sequence on the host end
   typedef enum logic [3:0] {
      CS_OFF  = 4'b0001,
      CS_RAMP = 4'b0010,
      CS_ON   = 4'b0100,
      CS_DOWN = 4'b1000
   } rps_core_state_t;
endpackage

/* hdl/rps_sync.sv */
`timescale 1ns/1ps
module rps_sync import rps_pkg::*; #(
   parameter int unsigned WIDTH = 1
) (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // asynchronous level in, synchronised level out
   input  wire logic [WIDTH-1:0] d_i,
   output logic      [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta;

   // two flip-flop chain; meta is read only by q_o
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta <= '0;
         q_o  <= '0;
      end else begin
         meta <= d_i;
         q_o  <= meta;
      end
   end
endmodule

/* tb/radio_power_reset_sequencer_tb.sv */
`timescale 1ns/1ps
module radio_power_reset_sequencer_tb;
   import rps_pkg::*;
   localparam int unsigned T_SETTLE = 4;
   localparam int unsigned T_RHOLD  = 4;

   logic        clk_i;
   logic        rst_i;
   logic        cyc_i;
   logic        stb_i;
   logic        we_i;
   logic [3:0]  adr_i;
   logic [3:0]  sel_i;
   logic [31:0] dat_i;
   logic [31:0] dat_o;
   logic        ack_o;
   logic        bus_ok;
   logic        wlan_rdy;
   logic        bt_rdy;
   logic [5:0]  dev;
   int          n_errors;
   int          checks;

   rps_if u_rps_if ();

   rps_host #(.HOLDOFF(50), .SETTLE(T_SETTLE), .RHOLD(T_RHOLD)) u_rps_host (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .pins(u_rps_if.host), .bus_access_ok_o(bus_ok), .wlan_ready_o(wlan_rdy),
      .bt_ready_o(bt_rdy));

   rps_device #(.RAMP(10)) u_rps_device (
      .clk_i(clk_i), .rst_i(rst_i), .pins(u_rps_if.device),
      .regulator_enable_o(dev[5]), .wlan_powered_o(dev[4]), .wlan_bus_enable_o(dev[3]),
      .bt_active_o(dev[2]), .fm_active_o(dev[1]), .bt_bus_enable_o(dev[0]));

   rps_assertions #(.SETTLE(T_SETTLE), .RHOLD(T_RHOLD)) u_rps_assertions (
      .clk_i(clk_i), .rst_i(rst_i),
      .wlan_power_request(u_rps_if.wlan_power_request),
      .bluetooth_power_request(u_rps_if.bluetooth_power_request),
      .wlan_core_reset_n(u_rps_if.wlan_core_reset_n),
      .bluetooth_core_reset_n(u_rps_if.bluetooth_core_reset_n),
      .core_supply_rail(u_rps_if.core_supply_rail));

   // pin levels packed as request w, request b, reset w, reset b, rail
   wire logic [4:0] pins = {u_rps_if.wlan_power_request, u_rps_if.bluetooth_power_request,
      u_rps_if.wlan_core_reset_n, u_rps_if.bluetooth_core_reset_n, u_rps_if.core_supply_rail};

   // 40 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   // verdict and end of run
   task automatic wrap_up();
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // compare seen against expected
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %0t %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   // one classic wishbone cycle, waits for ack under a bound
   task automatic wb(input logic we, input logic [3:0] adr, input logic [3:0] sel,
                     input logic [31:0] wd, output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= we;
      adr_i <= adr;
      sel_i <= sel;
      dat_i <= wd;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      if (n >= 50) begin
         n_errors++;
         $display("MISMATCH %0t bus ack timeout", $time);
         wrap_up();
      end
   endtask

   // poll the status word until it reaches the expected value
   task automatic wait_status(input logic [31:0] exp);
      logic [31:0] rd;
      int          n;
      n = 0;
      do begin
         wb(1'b0, STATUS_ADDR, 4'hF, 32'h0000_0000, rd);
         n++;
      end while (rd !== exp && n < 300);
      if (rd !== exp) begin
         n_errors++;
         $display("MISMATCH %0t status wait timeout %h", $time, rd);
         wrap_up();
      end
   endtask

   // write a control word, wait for settle, judge pins and chip sections
   task automatic set_mode(input logic [2:0] ctrl, input logic [31:0] st,
                           input logic [4:0] p_exp, input logic [5:0] d_exp);
      logic [31:0] rd;
      wb(1'b1, CTRL_ADDR, 4'h1, {29'h0, ctrl}, rd);
      wait_status(st);
      check({27'h0, pins}, {27'h0, p_exp}, "pin levels");
      check({26'h0, dev}, {26'h0, d_exp}, "chip sections");
      check({29'h0, bus_ok, wlan_rdy, bt_rdy},
            {29'h0, st[ST_ACCESS_BIT], p_exp[2], p_exp[1]}, "ready levels");
   endtask

   // reset, at start or from an active state, leaves every pin and section low
   task automatic t_reset();
      logic [31:0] rd;
      rst_i <= 1'b1;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      check({27'h0, pins}, 32'h0000_0000, "pins after reset");
      check({26'h0, dev}, 32'h0000_0000, "sections after reset");
      wb(1'b0, CTRL_ADDR, 4'hF, 32'h0000_0000, rd);
      check(rd, {29'h0, CTRL_RESET}, "control reset value");
   endtask

   // refused and unmapped accesses leave the control word alone
   task automatic t_refused();
      logic [31:0] rd;
      wb(1'b1, 4'h8, 4'hF, 32'hFFFF_FFFF, rd);
      wb(1'b1, CTRL_ADDR, 4'h0, 32'h0000_0000, rd);
      wb(1'b1, STATUS_ADDR, 4'hF, 32'h0000_0000, rd);
      wb(1'b0, CTRL_ADDR, 4'hF, 32'h0000_0000, rd);
      check(rd, 32'h0000_0004, "control after refused writes");
      wb(1'b0, 4'h8, 4'hF, 32'h0000_0000, rd);
      check(rd, 32'h0000_0000, "unmapped read");
      wb(1'b0, STATUS_ADDR, 4'hF, 32'h0000_0000, rd);
      check(rd, 32'h0000_001E, "status after refused writes");
   endtask

   // main sequence
   initial begin
      n_errors = 0;
      checks   = 0;
      cyc_i    = 1'b0;
      stb_i    = 1'b0;
      we_i     = 1'b0;
      adr_i    = 4'h0;
      sel_i    = 4'h0;
      dat_i    = 32'h0000_0000;
      t_reset();
      set_mode(3'h1, 32'h0000_0019, 5'b10101, 6'b111000);
      set_mode(3'h3, 32'h0000_001B, 5'b11111, 6'b111111);
      set_mode(3'h4, 32'h0000_001E, 5'b01011, 6'b100111);
      t_refused();
      set_mode(3'h0, 32'h0000_0000, 5'b00000, 6'b000000);
      set_mode(3'h3, 32'h0000_001B, 5'b11111, 6'b111111);
      t_reset();
      wrap_up();
   end
endmodule

/* tb/rps_assertions.sv */
`timescale 1ns/1ps
module rps_assertions #(
   parameter int unsigned SETTLE = 4,
   parameter int unsigned RHOLD  = 4
) (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // link pins
   input  wire logic wlan_power_request,
   input  wire logic bluetooth_power_request,
   input  wire logic wlan_core_reset_n,
   input  wire logic bluetooth_core_reset_n,
   input  wire logic core_supply_rail
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // regulator enable follows the or of both requests
   reg_or_off_a: assert property (
      (!wlan_power_request && !bluetooth_power_request) [*5] |-> !core_supply_rail)
      else $error("supply up with no request");
   rail_needs_req_a: assert property (
      $rose(core_supply_rail) |-> $past(wlan_power_request || bluetooth_power_request, 4))
      else $error("supply rose without request");
   // a released core always has its request up
   wlan_rel_req_a: assert property (
      wlan_core_reset_n |-> wlan_power_request)
      else $error("wlan released without request");
   bt_rel_req_a: assert property (
      bluetooth_core_reset_n |-> bluetooth_power_request)
      else $error("bt released without request");
   // release only after the supply has settled
   wlan_settle_a: assert property (
      $rose(wlan_core_reset_n) |-> core_supply_rail && $past(core_supply_rail, SETTLE))
      else $error("wlan released before settle");
   bt_settle_a: assert property (
      $rose(bluetooth_core_reset_n) |-> core_supply_rail && $past(core_supply_rail, SETTLE))
      else $error("bt released before settle");
   // request dropped only after reset held low
   wlan_hold_a: assert property (
      $fell(wlan_power_request) |-> !wlan_core_reset_n && !$past(wlan_core_reset_n, RHOLD))
      else $error("wlan request dropped too early");
   bt_hold_a: assert property (
      $fell(bluetooth_power_request)
      |-> !bluetooth_core_reset_n && !$past(bluetooth_core_reset_n, RHOLD))
      else $error("bt request dropped too early");
   // supply loss puts both cores in reset
   loss_reset_a: assert property (
      $fell(core_supply_rail) |-> ##[0:4] (!wlan_core_reset_n && !bluetooth_core_reset_n))
      else $error("core left running on supply loss");

   // main scenarios
   wlan_up_c: cover property ($rose(wlan_core_reset_n));
   bt_up_c: cover property ($rose(bluetooth_core_reset_n));
   rail_off_c: cover property ($fell(core_supply_rail));
endmodule
